//--- hdl/ecp_pkg.sv
package ecp_pkg;

  localparam int NUM_PORTS = 6;
  localparam int NUM_WORDS = 7;

  // Signature word; value is arbitrary
  localparam logic [15:0] SIG_WORD = 16'ha55a;

  // Preload word byte addresses
  localparam logic [7:0] EE_SIG = 8'h00;
  localparam logic [7:0] EE_VID = 8'h02;
  localparam logic [7:0] EE_DID = 8'h04;
  localparam logic [7:0] EE_W06 = 8'h06;
  localparam logic [7:0] EE_SVID = 8'h08;
  localparam logic [7:0] EE_SID = 8'h0a;
  localparam logic [7:0] EE_W0C = 8'h0c;

  // Defaults kept when no valid image is present; values are arbitrary
  localparam logic [15:0] DEF_VID = 16'h0000;
  localparam logic [15:0] DEF_DID = 16'h0000;
  localparam logic [15:0] DEF_W06 = 16'h0000;
  localparam logic [15:0] DEF_SVID = 16'h0000;
  localparam logic [15:0] DEF_SID = 16'h0000;
  localparam logic [15:0] DEF_W0C = 16'h0000;

  // Word 06h source fields
  localparam int W06_EVC = 0;
  localparam int W06_L0S = 1;
  localparam int W06_L1 = 4;
  localparam int W06_CLKPM = 7;
  localparam int W06_NOEGR = 8;
  localparam int W06_NOTAG = 9;
  localparam int W06_SAF = 10;
  localparam int W06_CUT = 11;
  localparam int W06_ARB = 13;
  localparam int W06_CRED = 14;
  localparam int W06_NPSAF = 15;

  // Word 0Ch source fields
  localparam int W0C_MPS = 0;
  localparam int W0C_ASPM = 2;
  localparam int W0C_ROLE = 4;
  localparam int W0C_MSIDIS = 5;
  localparam int W0C_PARDIS = 6;
  localparam int W0C_PMDIS = 7;

  // Configuration image bit positions
  localparam int LCAP_ASPM = 10;
  localparam int LCAP_L0S = 12;
  localparam int LCAP_L1 = 15;
  localparam int LCAP_CLKPM = 18;
  localparam int DCAP_MPS = 0;
  localparam int DCAP_ROLE = 15;
  localparam int CDIS_PM = 13;
  localparam int CDIS_MSI = 14;
  localparam int SWM_PARDIS = 15;
  localparam int EVC_CNT = 0;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IDS = 8'h08;
  localparam logic [7:0] REG_SUBIDS = 8'h0c;
  localparam logic [7:0] REG_LINKCAP = 8'h10;
  localparam logic [7:0] REG_DEVCAP = 8'h14;
  localparam logic [7:0] REG_CAPDIS = 8'h18;
  localparam logic [7:0] REG_SWMODE = 8'h1c;
  localparam logic [7:0] REG_EXTVC = 8'h20;
  localparam int CTRL_RELOAD = 0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } ecp_state_e;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ecp_ee_rsp_s;

  // Port 0 switch mode, bits 7:0 of its mode register
  typedef struct packed {
    logic npSafOnly;
    logic noTagOrder;
    logic noEgrOrder;
    logic credUpdMode;
    logic arbMode;
    logic [1:0] cutThr;
    logic storeFwd;
  } ecp_swmode_s;

  typedef struct packed {
    logic extVcCnt;
    logic [2:0] l0sExitLat;
    logic [2:0] l1ExitLat;
    logic clkPmCap;
    logic [1:0] aspmSupport;
    logic [1:0] maxPayload;
    logic roleErrRpt;
    logic msiCapDis;
    logic pmCapDis;
    logic parityDis;
  } ecp_port_cfg_s;

endpackage

//--- hdl/ecp_loader.sv
// Notes on behaviour
// RULE_01: Word 06h bit 0 sets extended VC count bit 0 on all ports.
// RULE_02: Word 06h bits 3:1 set link-cap L0s exit latency on all ports.
// RULE_03: Word 06h bits 6:4 set link-cap L1 exit latency on all ports.
// RULE_04: Word 06h bit 7 sets link-cap clock PM capability on all ports.
// RULE_05: Word 06h bit 8 sets port 0 no-egress-ordering mode.
// RULE_06: Word 06h bit 9 sets port 0 no-tag-ordering for completions.
// RULE_07: Word 06h bit 10 sets port 0 store-and-forward.
// RULE_08: Word 06h bits 12:11 set port 0 cut-through threshold.
// RULE_09: Word 06h bit 13 sets port 0 arbiter mode.
// RULE_10: Word 06h bit 14 sets port 0 credit update mode.
// RULE_11: Word 06h bit 15 sets port 0 non-posted store-and-forward only.
// RULE_12: Word 0Ch bits 1:0 set max payload support on all ports.
// RULE_13: Word 0Ch bits 3:2 set link-cap ASPM support on all ports.
// RULE_14: Word 0Ch bit 4 sets role-based error reporting on all ports.
// RULE_15: Word 0Ch bit 5 removes MSI capability on all ports.
// RULE_16: Word 0Ch bit 6 disables compliance pattern parity on all ports.
// RULE_17: Word 0Ch bit 7 removes power management capability on all ports.
// RULE_18: Word 00h read first; bad signature keeps all defaults.
// RULE_19: Words 02h/04h/08h/0Ah load vendor, device, subvendor, subsys IDs.
// RULE_20: The EEPROM image holds each word at its listed address.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module ecp_loader (
  input wire logic clk_sys, // 50 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  output logic eeReq, // Word read request pulse
  output logic [7:0] eeAddr, // Word byte address
  input wire ecp_pkg::ecp_ee_rsp_s eeRsp, // Returned word
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [31:0] regWdata, // Register write data
  input wire logic regWe, // Register write strobe
  input wire logic regRe, // Register read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  output logic loadDone, // Preload finished
  output logic [15:0] vendorId, // Vendor identifier
  output logic [15:0] deviceId, // Device identifier
  output logic [15:0] subVendorId, // Subsystem vendor identifier
  output logic [15:0] subsysId, // Subsystem identifier
  output ecp_pkg::ecp_swmode_s swMode0, // Port 0 switch mode
  output ecp_pkg::ecp_port_cfg_s [5:0] portCfg // Per-port settings
);
  import ecp_pkg::*;

  ecp_state_e state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic startPend_reg, startPend_next;
  logic sigOk_reg, sigOk_next;
  logic sigBad_reg, sigBad_next;
  logic [15:0] vid_reg, vid_next;
  logic [15:0] did_reg, did_next;
  logic [15:0] svid_reg, svid_next;
  logic [15:0] sid_reg, sid_next;
  logic [15:0] w06_reg, w06_next;
  logic [15:0] w0c_reg, w0c_next;
  logic [31:0] rdata_reg, rdata_next;

  wire cap = (state_reg == ST_WAIT) && eeRsp.valid;
  wire lastWord = (idx_reg == 3'(NUM_WORDS - 1));
  wire [7:0] curAddr = {4'h0, idx_reg, 1'b0};
  wire sigMatch = (eeRsp.data == SIG_WORD);
  wire reloadWr = regWe && (regAddr == REG_CTRL)
                  && regWdata[CTRL_RELOAD];

  // FSM: one word in flight at a time
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    startPend_next = startPend_reg | reloadWr;
    sigOk_next = sigOk_reg;
    sigBad_next = sigBad_reg;
    vid_next = vid_reg;
    did_next = did_reg;
    svid_next = svid_reg;
    sid_next = sid_reg;
    w06_next = w06_reg;
    w0c_next = w0c_reg;
    case (state_reg)
      ST_IDLE, ST_DONE:
      begin
        if (startPend_reg)
        begin
          startPend_next = reloadWr;
          state_next = ST_REQ;
          idx_next = 3'd0;
          sigOk_next = 1'b0;
          sigBad_next = 1'b0;
          vid_next = DEF_VID;
          did_next = DEF_DID;
          svid_next = DEF_SVID;
          sid_next = DEF_SID;
          w06_next = DEF_W06;
          w0c_next = DEF_W0C;
        end
      end
      ST_REQ:
        state_next = ST_WAIT;
      ST_WAIT:
      begin
        if (eeRsp.valid)
        begin
          state_next = lastWord ? ST_DONE : ST_REQ;
          idx_next = idx_reg + 3'd1;
          if (curAddr == EE_SIG)
          begin
            sigOk_next = sigMatch; // [RULE_18]
            sigBad_next = !sigMatch;
            if (!sigMatch)
              state_next = ST_DONE; // [RULE_18]
          end
          else if (curAddr == EE_VID)
            vid_next = eeRsp.data; // [RULE_19]
          else if (curAddr == EE_DID)
            did_next = eeRsp.data; // [RULE_19]
          else if (curAddr == EE_W06)
            w06_next = eeRsp.data;
          else if (curAddr == EE_SVID)
            svid_next = eeRsp.data; // [RULE_19]
          else if (curAddr == EE_SID)
            sid_next = eeRsp.data; // [RULE_19]
          else
            w0c_next = eeRsp.data;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      idx_reg <= 3'd0;
      startPend_reg <= 1'b1;
      sigOk_reg <= 1'b0;
      sigBad_reg <= 1'b0;
      vid_reg <= DEF_VID;
      did_reg <= DEF_DID;
      svid_reg <= DEF_SVID;
      sid_reg <= DEF_SID;
      w06_reg <= DEF_W06;
      w0c_reg <= DEF_W0C;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      startPend_reg <= startPend_next;
      sigOk_reg <= sigOk_next;
      sigBad_reg <= sigBad_next;
      vid_reg <= vid_next;
      did_reg <= did_next;
      svid_reg <= svid_next;
      sid_reg <= sid_next;
      w06_reg <= w06_next;
      w0c_reg <= w0c_next;
      rdata_reg <= rdata_next;
    end
  end

  assign eeReq = (state_reg == ST_REQ);
  assign eeAddr = curAddr;
  assign loadDone = (state_reg == ST_DONE);
  assign vendorId = vid_reg;
  assign deviceId = did_reg;
  assign subVendorId = svid_reg;
  assign subsysId = sid_reg;

  // Port 0 switch mode from word 06h
  assign swMode0.noEgrOrder = w06_reg[W06_NOEGR]; // [RULE_05]
  assign swMode0.noTagOrder = w06_reg[W06_NOTAG]; // [RULE_06]
  assign swMode0.storeFwd = w06_reg[W06_SAF]; // [RULE_07]
  assign swMode0.cutThr = w06_reg[W06_CUT +: 2]; // [RULE_08]
  assign swMode0.arbMode = w06_reg[W06_ARB]; // [RULE_09]
  assign swMode0.credUpdMode = w06_reg[W06_CRED]; // [RULE_10]
  assign swMode0.npSafOnly = w06_reg[W06_NPSAF]; // [RULE_11]

  // Same settings fan out to every port
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      assign portCfg[gp].extVcCnt = w06_reg[W06_EVC]; // [RULE_01]
      assign portCfg[gp].l0sExitLat = w06_reg[W06_L0S +: 3]; // [RULE_02]
      assign portCfg[gp].l1ExitLat = w06_reg[W06_L1 +: 3]; // [RULE_03]
      assign portCfg[gp].clkPmCap = w06_reg[W06_CLKPM]; // [RULE_04]
      assign portCfg[gp].maxPayload = w0c_reg[W0C_MPS +: 2]; // [RULE_12]
      assign portCfg[gp].aspmSupport = w0c_reg[W0C_ASPM +: 2]; // [RULE_13]
      assign portCfg[gp].roleErrRpt = w0c_reg[W0C_ROLE]; // [RULE_14]
      assign portCfg[gp].msiCapDis = w0c_reg[W0C_MSIDIS]; // [RULE_15]
      assign portCfg[gp].parityDis = w0c_reg[W0C_PARDIS]; // [RULE_16]
      assign portCfg[gp].pmCapDis = w0c_reg[W0C_PMDIS]; // [RULE_17]
    end
  endgenerate

  // Configuration images as seen on port 0
  wire [31:0] linkCapImg = (32'(portCfg[0].aspmSupport) << LCAP_ASPM)
                         | (32'(portCfg[0].l0sExitLat) << LCAP_L0S)
                         | (32'(portCfg[0].l1ExitLat) << LCAP_L1)
                         | (32'(portCfg[0].clkPmCap) << LCAP_CLKPM);
  wire [31:0] devCapImg = (32'(portCfg[0].maxPayload) << DCAP_MPS)
                        | (32'(portCfg[0].roleErrRpt) << DCAP_ROLE);
  wire [31:0] capDisImg = (32'(portCfg[0].pmCapDis) << CDIS_PM)
                        | (32'(portCfg[0].msiCapDis) << CDIS_MSI);
  wire [31:0] swModeImg = (32'(portCfg[0].parityDis) << SWM_PARDIS)
                        | 32'(swMode0);
  wire [31:0] extVcImg = 32'(portCfg[0].extVcCnt) << EVC_CNT;
  wire [31:0] statusImg = {28'h0000000, sigBad_reg, sigOk_reg,
                           loadDone, !(state_reg == ST_IDLE
                           || state_reg == ST_DONE)};
  wire [31:0] rdSel;

  assign rdSel = (regAddr == REG_STATUS) ? statusImg
               : (regAddr == REG_IDS) ? {did_reg, vid_reg}
               : (regAddr == REG_SUBIDS) ? {sid_reg, svid_reg}
               : (regAddr == REG_LINKCAP) ? linkCapImg
               : (regAddr == REG_DEVCAP) ? devCapImg
               : (regAddr == REG_CAPDIS) ? capDisImg
               : (regAddr == REG_SWMODE) ? swModeImg
               : (regAddr == REG_EXTVC) ? extVcImg
               : 32'h0000_0000;

  assign rdata_next = regRe ? rdSel : 32'h0000_0000;
  assign regRdata = rdata_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  wire capSig = cap && (curAddr == EE_SIG);
  wire capW06 = cap && (curAddr == EE_W06);
  wire capW0C = cap && (curAddr == EE_W0C);

  AST_SIG_BAD: assert property ( // [RULE_18]
    capSig && !sigMatch && !startPend_next |=> loadDone && !sigOk_reg
      && sigBad_reg && vendorId == DEF_VID && !eeReq [*2])
    else $error("Bad signature did not stop the load");

  AST_SIG_FIRST: assert property ( // [RULE_18]
    eeReq && !sigOk_reg |-> eeAddr == EE_SIG)
    else $error("Later word requested before a good signature");

  AST_IDS: assert property ( // [RULE_19]
    cap && curAddr == EE_DID |=> deviceId == $past(eeRsp.data))
    else $error("Device identifier not loaded");

  AST_LINKCAP: assert property ( // [RULE_02]
    capW06 |=> linkCapImg[LCAP_L0S +: 3] == $past(eeRsp.data[3:1])
      && linkCapImg[LCAP_L1 +: 3] == $past(eeRsp.data[6:4])
      && linkCapImg[LCAP_CLKPM] == $past(eeRsp.data[7]))
    else $error("Link capability latency fields wrong");

  AST_EXTVC: assert property ( // [RULE_01]
    capW06 |=> portCfg[5].extVcCnt == $past(eeRsp.data[0])
      && portCfg[0].extVcCnt == portCfg[5].extVcCnt)
    else $error("Extended VC count not copied to all ports");

  AST_SWMODE: assert property ( // [RULE_07]
    capW06 |=> swModeImg[7:0] == {$past(eeRsp.data[15]),
      $past(eeRsp.data[9]), $past(eeRsp.data[8]),
      $past(eeRsp.data[14]), $past(eeRsp.data[13]),
      $past(eeRsp.data[12:11]), $past(eeRsp.data[10])})
    else $error("Port 0 switch mode mapping wrong");

  AST_DEVCAP: assert property ( // [RULE_12]
    capW0C |=> devCapImg == {16'h0000, $past(eeRsp.data[4]), 13'h0000,
      $past(eeRsp.data[1:0])} && loadDone)
    else $error("Device capability image wrong");

  AST_CAPDIS: assert property ( // [RULE_15]
    capW0C |=> capDisImg[CDIS_MSI] == $past(eeRsp.data[5])
      && capDisImg[CDIS_PM] == $past(eeRsp.data[7])
      && portCfg[3].parityDis == $past(eeRsp.data[6])
      && portCfg[2].aspmSupport == $past(eeRsp.data[3:2]))
    else $error("Capability disable bits wrong");

  AST_L1_LAT: assert property ( // [RULE_03]
    capW06 |=> portCfg[4].l1ExitLat == $past(eeRsp.data[6:4]))
    else $error("L1 exit latency not copied");

  AST_CLKPM: assert property ( // [RULE_04]
    capW06 |=> portCfg[1].clkPmCap == $past(eeRsp.data[7]))
    else $error("Clock PM capability not copied");

  AST_NO_EGR: assert property ( // [RULE_05]
    capW06 |=> swModeImg[5] == $past(eeRsp.data[8]))
    else $error("Egress ordering mode bit wrong");

  AST_NO_TAG: assert property ( // [RULE_06]
    capW06 |=> swModeImg[6] == $past(eeRsp.data[9]))
    else $error("Tag ordering mode bit wrong");

  AST_CUT_THR: assert property ( // [RULE_08]
    capW06 |=> swModeImg[2:1] == $past(eeRsp.data[12:11]))
    else $error("Cut-through threshold wrong");

  AST_ARB: assert property ( // [RULE_09]
    capW06 |=> swModeImg[3] == $past(eeRsp.data[13]))
    else $error("Arbiter mode bit wrong");

  AST_CRED: assert property ( // [RULE_10]
    capW06 |=> swModeImg[4] == $past(eeRsp.data[14]))
    else $error("Credit update mode bit wrong");

  AST_NP_SAF: assert property ( // [RULE_11]
    capW06 |=> swModeImg[7] == $past(eeRsp.data[15]))
    else $error("Non-posted store-and-forward bit wrong");

  AST_ASPM: assert property ( // [RULE_13]
    capW0C |=> linkCapImg[LCAP_ASPM +: 2] == $past(eeRsp.data[3:2]))
    else $error("ASPM support field wrong");

  AST_ROLE: assert property ( // [RULE_14]
    capW0C |=> portCfg[5].roleErrRpt == $past(eeRsp.data[4]))
    else $error("Role-based error reporting bit wrong");

  AST_PARITY: assert property ( // [RULE_16]
    capW0C |=> swModeImg[SWM_PARDIS] == $past(eeRsp.data[6]))
    else $error("Compliance parity disable bit wrong");

  AST_PM_DIS: assert property ( // [RULE_17]
    capW0C |=> portCfg[4].pmCapDis == $past(eeRsp.data[7]))
    else $error("PM capability disable bit wrong");

  AST_VID: assert property ( // [RULE_19]
    cap && curAddr == EE_VID |=> vendorId == $past(eeRsp.data))
    else $error("Vendor identifier not loaded");

  AST_SUBIDS: assert property ( // [RULE_19]
    cap && curAddr == EE_SID |=> subsysId == $past(eeRsp.data))
    else $error("Subsystem identifier not loaded");

  AST_ONE_REQ: assert property ( // [RULE_18]
    eeReq |=> !eeReq)
    else $error("Second word requested before an answer");

  AST_RDATA: assert property (
    regRe ##1 !regRe |-> ##1 regRdata == 32'h0000_0000)
    else $error("Read data stood longer than one cycle");

  COV_GOOD_LOAD: cover property (capW0C ##1 loadDone && sigOk_reg);
  COV_BAD_SIG: cover property (capSig && !sigMatch);
  COV_RELOAD: cover property (loadDone && reloadWr ##2 eeReq);
  COV_STATUS_RD: cover property (regRe && regAddr == REG_STATUS);

endmodule

//--- tb/ecp_eeprom_model.sv
`timescale 1ns/100ps
module ecp_eeprom_model
  import ecp_pkg::*;
(
  input wire logic clk_sys, // Core clock
  input wire logic eeReq, // Word request
  input wire logic [7:0] eeAddr, // Word byte address
  input wire logic [15:0] img [NUM_WORDS], // Stored words
  input wire logic [3:0] dly, // Extra answer delay
  output ecp_pkg::ecp_ee_rsp_s eeRsp // Returned word
);
  logic [2:0] idx;

  initial
  begin
    eeRsp = '0;
    forever
    begin
      @(posedge clk_sys);
      if (eeReq === 1'b1)
      begin
        idx = eeAddr[3:1];
        repeat (dly) @(posedge clk_sys);
        eeRsp <= '{valid: 1'b1, data: img[idx]};
        @(posedge clk_sys);
        // Released bus shows the inverse, not the old word
        eeRsp <= '{valid: 1'b0, data: ~img[idx]};
      end
    end
  end
endmodule

//--- tb/ecp_loader_bench.sv
`timescale 1ns/100ps
module ecp_loader_bench;
  import ecp_pkg::*;
  logic clk_sys, rst, regWe, regRe, eeReq, loadDone;
  logic [7:0] regAddr, eeAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [15:0] vendorId, deviceId, subVendorId, subsysId;
  ecp_ee_rsp_s eeRsp;
  ecp_swmode_s swMode0;
  ecp_port_cfg_s [5:0] portCfg;
  logic [15:0] img [NUM_WORDS];
  logic [3:0] dly;
  int errors, samples_checked, seed;
  logic [7:0] addrQ [$];

  ecp_loader u_dut (.clk_sys(clk_sys), .rst(rst), .eeReq(eeReq),
    .eeAddr(eeAddr), .eeRsp(eeRsp), .regAddr(regAddr),
    .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata), .loadDone(loadDone), .vendorId(vendorId),
    .deviceId(deviceId), .subVendorId(subVendorId), .subsysId(subsysId),
    .swMode0(swMode0), .portCfg(portCfg));

  ecp_eeprom_model u_ee (.clk_sys(clk_sys), .eeReq(eeReq),
    .eeAddr(eeAddr), .img(img), .dly(dly), .eeRsp(eeRsp));

  always @(posedge clk_sys)
    if (eeReq === 1'b1)
      addrQ.push_back(eeAddr);

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWe <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWe <= 1'b0;
  endtask

  task reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regRe <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRe <= 1'b0;
    @(negedge clk_sys);
    v = regRdata;
  endtask

  task wait_done;
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (loadDone !== 1'b1 && n < 500)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 500), 32'h1, "load finish");
  endtask

  task check_all(input bit good);
    logic [15:0] w6, wc, vid, did;
    ecp_swmode_s sm;
    ecp_port_cfg_s pc;
    w6 = good ? img[3] : DEF_W06;
    wc = good ? img[6] : DEF_W0C;
    vid = good ? img[1] : DEF_VID;
    did = good ? img[2] : DEF_DID;
    sm = {w6[15], w6[9], w6[8], w6[14], w6[13], w6[12:11], w6[10]};
    pc = {w6[0], w6[3:1], w6[6:4], w6[7], wc[3:2], wc[1:0], wc[4], wc[5],
      wc[7], wc[6]};
    chk(32'(swMode0), 32'(sm), "mode");
    for (int p = 0; p < NUM_PORTS; p++)
      chk(32'(portCfg[p]), 32'(pc), "port");
    chk({deviceId, vendorId}, {did, vid}, "ids");
    chk({subsysId, subVendorId}, good ? {img[5], img[4]} :
      {DEF_SID, DEF_SVID}, "subids");
    reg_rd(REG_IDS, d);
    chk(d, {did, vid}, "id reg");
    reg_rd(REG_STATUS, d);
    chk(d, good ? 32'h6 : 32'ha, "status");
    reg_rd(REG_LINKCAP, d);
    chk(d,
      32'(wc[3:2]) << 10 | 32'(w6[7:1]) << 12, "lcap");
    reg_rd(REG_DEVCAP, d);
    chk(d, 32'(wc[1:0]) | 32'(wc[4]) << 15, "dcap");
    reg_rd(REG_CAPDIS, d);
    chk(d, 32'(wc[7]) << 13 | 32'(wc[5]) << 14,
      "capdis");
    reg_rd(REG_SWMODE, d);
    chk(d,
      32'(sm) | 32'(wc[6]) << 15, "swm");
    reg_rd(REG_EXTVC, d);
    chk(d, 32'(w6[0]), "extvc");
    chk(addrQ.size(), good ? 7 : 1, "req count");
    for (int i = 0; i < addrQ.size(); i++)
      chk(32'(addrQ[i]), 32'(2 * i), "req order");
  endtask

  task new_image(input bit good);
    for (int i = 0; i < NUM_WORDS; i++)
      img[i] = 16'($random(seed));
    img[0] = good ? SIG_WORD : ~SIG_WORD;
  endtask

  task reload;
    addrQ.delete();
    reg_wr(REG_CTRL, 32'($random(seed)) | 32'h1);
    wait_done;
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    #400000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end

  initial
  begin
    seed = 91852;
    rst = 1'b1;
    regWe = 1'b0;
    regRe = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    dly = 4'h2;
    new_image(1'b1);
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wait_done;
    check_all(1'b1);
    $display("test power-up load ended");
    for (int k = 0; k < 4; k++)
    begin
      new_image(1'b1);
      dly <= 4'(k * 3);
      reload;
      check_all(1'b1);
      reg_rd(8'h24, d);
      chk(d, 32'h0, "unmapped");
      reg_rd(REG_CTRL, d);
      chk(d, 32'h0, "ctrl read");
      $display("test reload %0d ended", k);
    end
    new_image(1'b0);
    reload;
    check_all(1'b0);
    $display("test bad signature ended");
    give_verdict;
  end
endmodule
